// >>> design/gpcsr_regs.sv
// Purpose: axi4-lite register bank for gigabit phy control and status
// Assumes: status and event inputs come from phy logic on aclk
//          events are one-cycle pulses, one count or set per cycle
// Notes: read-to-clear effects happen on the read address handshake
//        write answer comes two cycles after both channels are taken

`timescale 1ns/1ps
`default_nettype none

module gpcsr_regs
	import gpcsr_pkg::*;
(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write address and data
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// control toward phy core
	output logic [2:0]             test_mode,
	output logic                   manual_role_en,
	output logic                   manual_role_master,
	output logic                   multi_port,
	output logic                   adv_gb_full,
	output logic                   adv_gb_half,
	output logic                   role_is_master,
	// master/slave status from phy core
	input  wire logic              auto_role_master,
	input  wire logic              ms_fault_event,
	input  wire logic              resolved_master,
	input  wire logic              local_rx_ok,
	input  wire logic              remote_rx_ok,
	input  wire logic              partner_gb_full,
	input  wire logic              partner_gb_half,
	input  wire logic              idle_error_event,
	// fast mode status: events are lock, disconnect, rx, tx, ssd, esd
	input  wire logic              fx_descr_locked,
	input  wire logic              fx_link_up,
	input  wire logic [5:0]        fx_events,
	// gigabit status: events as fast mode plus carrier extension
	input  wire logic              gb_descr_locked,
	input  wire logic              gb_link_up,
	input  wire logic [6:0]        gb_events,
	input  wire logic              gb_noncompliant_partner,
	input  wire logic              gb_crossover_error,
	// extended device access port
	output logic [4:0]             xa_device,
	output logic [15:0]            xa_address,
	output logic [15:0]            xa_wdata,
	output logic                   xa_write,
	output logic                   xa_read,
	input  wire logic [15:0]       xa_rdata
);

	// write holding state
	// address and data may arrive in either order
	logic                aw_held;
	logic                w_held;
	logic [5:0]          aw_idx;
	logic                aw_bad;
	logic [15:0]         w_data;
	logic [1:0]          w_strb;
	logic                do_wr;
	logic                do_rd;
	logic [5:0]          ar_idx;
	logic                ar_bad;
	// register fields
	logic [1:0]          xa_fn;
	logic                ms_fault;
	logic [7:0]          idle_count;
	logic [5:0]          fx_flags;
	logic [6:0]          gb_flags;
	// read mux results
	logic [15:0]         rd_word;
	logic                rd_hit;
	logic                rd_clr_stat;
	logic                rd_clr_fx;
	logic                rd_clr_gb;
	logic                wr_win_data;
	logic                rd_win_data;
	logic                wr_inc;
	logic                rd_inc;

	// handshakes: each channel taken once, write done when both held
	// read ready follows the answer so a second read cannot overrun rdata
	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_wr         = aw_held && w_held && !s_axi_bvalid;
	assign do_rd         = s_axi_arvalid && s_axi_arready;
	assign ar_idx        = s_axi_araddr[7:2];
	assign ar_bad        = |s_axi_araddr[1:0];

	// capture write address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_idx  <= 6'h00;
			aw_bad  <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_idx  <= s_axi_awaddr[7:2];
			aw_bad  <= |s_axi_awaddr[1:0];
		end else if (do_wr) begin
			aw_held <= 1'b0;
		end
	end

	// capture write data, only the low two lanes matter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 16'h0000;
			w_strb <= 2'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata[15:0];
			w_strb <= s_axi_wstrb[1:0];
		end else if (do_wr) begin
			w_held <= 1'b0;
		end
	end

	// write response
	// a held write waits here while an earlier answer still stands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_bad || !wr_hit(aw_idx)) ? RESP_DECERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// mapped indices
	// anything outside this list answers with a decode error
	function automatic logic wr_hit(input logic [5:0] idx);
		wr_hit = (idx == IDX_GB_CTRL) || (idx == IDX_GB_STAT) || (idx == IDX_XA_CTRL) ||
			(idx == IDX_XA_WIN) || (idx == IDX_XABILITY) || (idx == IDX_FX_STAT) ||
			(idx == IDX_GB_XSTAT);
	endfunction

	// gigabit control register, reserved low byte not stored
	// reserved test codes are stored as written; the core decides
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			test_mode          <= TM_RESET;
			manual_role_en     <= 1'b0;
			manual_role_master <= 1'b0;
			multi_port         <= 1'b0;
			adv_gb_full        <= ADV_RESET;
			adv_gb_half        <= ADV_RESET;
		end else if (do_wr && !aw_bad && aw_idx == IDX_GB_CTRL && w_strb[1]) begin
			test_mode          <= w_data[CTRL_TM_LSB +: 3];
			manual_role_en     <= w_data[CTRL_MAN_EN];
			manual_role_master <= w_data[CTRL_MAN_VAL];
			multi_port         <= w_data[CTRL_PORT];
			adv_gb_full        <= w_data[CTRL_ADV_FD];
			adv_gb_half        <= w_data[CTRL_ADV_HD];
		end
	end

	// role override: manual value only counts while enabled
	// registered, so the core sees a change one cycle after the write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			role_is_master <= 1'b0;
		end else begin
			role_is_master <= manual_role_en ? manual_role_master : auto_role_master;
		end
	end

	// extended access control: function and device address
	// the function lane and the device lane are written independently
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xa_fn     <= FN_ADDR;
			xa_device <= 5'h00;
		end else if (do_wr && !aw_bad && aw_idx == IDX_XA_CTRL) begin
			if (w_strb[1]) begin
				xa_fn <= w_data[XA_FN_LSB +: 2];
			end
			if (w_strb[0]) begin
				xa_device <= w_data[4:0];
			end
		end
	end

	// window decode: function 00 addresses, others move data
	// a data write needs both lanes, half a word would corrupt the target
	assign wr_win_data = do_wr && !aw_bad && aw_idx == IDX_XA_WIN && (&w_strb) && xa_fn != FN_ADDR;
	assign rd_win_data = do_rd && !ar_bad && ar_idx == IDX_XA_WIN && xa_fn != FN_ADDR;
	assign wr_inc      = wr_win_data && (xa_fn == FN_DATA_INC || xa_fn == FN_DATA_INCW);
	assign rd_inc      = rd_win_data && xa_fn == FN_DATA_INC;

	// extended register address with post-increment
	// the step lands with the strobe, so the far side latches the old address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xa_address <= WIN_RESET;
		end else if (do_wr && !aw_bad && aw_idx == IDX_XA_WIN && xa_fn == FN_ADDR) begin
			if (w_strb[0]) begin
				xa_address[7:0] <= w_data[7:0];
			end
			if (w_strb[1]) begin
				xa_address[15:8] <= w_data[15:8];
			end
		end else begin
			xa_address <= xa_address + {15'h0000, wr_inc} + {15'h0000, rd_inc};
		end
	end

	// data strobes toward the extended device space
	// one-cycle pulses; the data word is held until the next data write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xa_write <= 1'b0;
			xa_read  <= 1'b0;
			xa_wdata <= WIN_RESET;
		end else begin
			xa_write <= wr_win_data;
			xa_read  <= rd_win_data;
			if (wr_win_data) begin
				xa_wdata <= w_data;
			end
		end
	end

	// read-to-clear decode
	// clears act on the address handshake, after the word is captured
	assign rd_clr_stat = do_rd && !ar_bad && ar_idx == IDX_GB_STAT;
	assign rd_clr_fx   = do_rd && !ar_bad && ar_idx == IDX_FX_STAT;
	assign rd_clr_gb   = do_rd && !ar_bad && ar_idx == IDX_GB_XSTAT;

	// fault latch, a new event wins over the read clear
	// losing a fault that lands on the read would hide it from software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ms_fault <= 1'b0;
		end else begin
			ms_fault <= (ms_fault && !rd_clr_stat) || ms_fault_event;
		end
	end

	// idle error counter, saturating, cleared by read
	// an error in the clearing cycle restarts the count at one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idle_count <= 8'h00;
		end else if (rd_clr_stat) begin
			idle_count <= {7'h00, idle_error_event};
		end else if (idle_error_event && idle_count != IDLE_MAX) begin
			idle_count <= idle_count + 8'h01;
		end
	end

	// sticky event flags, set wins over read clear
	// live status bits are not latched and read straight from the core
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fx_flags <= 6'h00;
			gb_flags <= 7'h00;
		end else begin
			fx_flags <= (rd_clr_fx ? 6'h00 : fx_flags) | fx_events;
			gb_flags <= (rd_clr_gb ? 7'h00 : gb_flags) | gb_events;
		end
	end

	// read mux; unlisted bits stay zero
	// misaligned or unmapped reads return zero with a decode error
	always_comb begin
		rd_word = 16'h0000;
		rd_hit  = !ar_bad;
		unique case (ar_idx)
			IDX_GB_CTRL: begin
				rd_word = {test_mode, manual_role_en, manual_role_master, multi_port,
					adv_gb_full, adv_gb_half, 8'h00};
			end
			IDX_GB_STAT: begin
				rd_word = {ms_fault, resolved_master, local_rx_ok, remote_rx_ok,
					partner_gb_full, partner_gb_half, 2'h0, idle_count};
			end
			IDX_XA_CTRL: begin
				rd_word = {xa_fn, 9'h000, xa_device};
			end
			IDX_XA_WIN: begin
				rd_word = (xa_fn == FN_ADDR) ? xa_address : xa_rdata;
			end
			IDX_XABILITY: begin
				rd_word = XABILITY_VAL;
			end
			IDX_FX_STAT: begin
				rd_word = {fx_descr_locked, fx_flags[5:4], fx_link_up, fx_flags[3:0], 8'h00};
			end
			IDX_GB_XSTAT: begin
				rd_word = {gb_descr_locked, gb_flags[6:5], gb_link_up, gb_flags[4:0],
					gb_noncompliant_partner, gb_crossover_error, 5'h00};
			end
			default: begin
				rd_word = 16'h0000;
				rd_hit  = 1'b0;
			end
		endcase
	end

	// read answer one cycle after the address is taken
	// rdata stands unchanged until rready is seen high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (do_rd) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_hit ? {16'h0000, rd_word} : 32'h00000000;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // gpcsr_regs

`default_nettype wire

// >>> dv/gige_phy_control_status_regs_tb_top.sv
// Purpose: self-checking bench for the gigabit register bank
// Assumes: bank answers over axi4-lite, device model on the access port
// Notes: random stimulus from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module gige_phy_control_status_regs_tb_top import gpcsr_pkg::*;;
	localparam logic [7:0] A_CTRL = {IDX_GB_CTRL, 2'b00};
	localparam logic [7:0] A_STAT = {IDX_GB_STAT, 2'b00};
	localparam logic [7:0] A_XCTL = {IDX_XA_CTRL, 2'b00};
	localparam logic [7:0] A_WIN = {IDX_XA_WIN, 2'b00};
	localparam logic [7:0] A_XAB = {IDX_XABILITY, 2'b00};
	localparam logic [7:0] A_FX = {IDX_FX_STAT, 2'b00};
	localparam logic [7:0] A_GB = {IDX_GB_XSTAT, 2'b00};
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, auto_role_master = 1'b0, ms_fault_event = 1'b0;
	logic resolved_master = 1'b0, local_rx_ok = 1'b0, remote_rx_ok = 1'b0, partner_gb_full = 1'b0;
	logic partner_gb_half = 1'b0, idle_error_event = 1'b0, fx_descr_locked = 1'b0, fx_link_up = 1'b0;
	logic gb_descr_locked = 1'b0, gb_link_up = 1'b0, gb_noncompliant_partner = 1'b0, gb_crossover_error = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, xa_write, xa_read;
	logic manual_role_en, manual_role_master, multi_port, adv_gb_full, adv_gb_half, role_is_master;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  test_mode;
	logic [5:0]  fx_events = 6'h00;
	logic [6:0]  gb_events = 7'h00;
	logic [4:0]  xa_device;
	logic [15:0] xa_address, xa_wdata, xa_rdata, a;
	logic [15:0] sh [16] = '{default: 16'h0000};
	int          n_fail = 0, comparisons = 0, n, k, n_xw = 0, n_xr = 0;
	gpcsr_regs dut (.*);
	gpcsr_xdev u_xdev (.*);
	// clock
	always #2.5 aclk = ~aclk;
	// count access strobes toward the device model
	always @(posedge aclk) begin
		if (xa_write) n_xw <= n_xw + 1;
		if (xa_read) n_xr <= n_xr + 1;
	end
	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("mismatches %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wc(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
			if (i == 2) s_axi_bready <= 1'b1; // late ready makes the answer stand
		end
		s_axi_bready <= 1'b0;
		if (i == 64) begin
			n_fail++;
			close_out();
		end
		ck(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic rc(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
		int i;
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (i == 1) s_axi_rready <= 1'b1; // late ready makes the answer stand
		end
		s_axi_rready <= 1'b0;
		if (i == 64) begin
			n_fail++;
			close_out();
		end
		ck(s_axi_rdata, e);
		ck(32'(s_axi_rresp), 32'(er));
	endtask
	function automatic logic [31:0] fx_exp(input logic [31:0] w, input logic e);
		return {16'h0, w[18], e & w[5], e & w[4], w[17], e ? w[3:0] : 4'h0, 8'h00};
	endfunction
	function automatic logic [31:0] gb_exp(input logic [31:0] w, input logic e);
		return {16'h0, w[16], e & w[12], e & w[11], w[15], e ? w[10:6] : 5'h0, w[14], w[13], 5'h00};
	endfunction
	// main sequence
	initial begin
		v = $urandom(32'h62FFB032);
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rc(A_CTRL, 32'h0300, RESP_OKAY);
		rc(A_XCTL, 32'h0, RESP_OKAY);
		rc(A_XAB, 32'h3000, RESP_OKAY);
		rc(8'h00, 32'h0, RESP_DECERR);
		rc(8'h25, 32'h0, RESP_DECERR);
		wc(8'h30, 32'hFFFF, RESP_DECERR);
		for (n = 0; n < 8; n++) begin
			v = $urandom;
			v[31:13] = {16'h0, n[2:0]};
			auto_role_master <= v[0];
			wc(A_CTRL, v, RESP_OKAY);
			rc(A_CTRL, v & 32'hFF00, RESP_OKAY);
			ck(32'(test_mode), 32'(n[2:0]));
			ck(32'({manual_role_en, manual_role_master, multi_port, adv_gb_full, adv_gb_half}), 32'(v[12:8]));
			ck(32'(role_is_master), 32'(v[12] ? v[11] : v[0]));
		end
		s_axi_wstrb <= 4'h1;
		wc(A_CTRL, 32'h0000, RESP_OKAY);
		rc(A_CTRL, v & 32'hFF00, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(A_CTRL, 32'h0300, RESP_OKAY);
		ck(32'(role_is_master), 32'(v[0]));
		v = $urandom;
		{resolved_master, local_rx_ok, remote_rx_ok, partner_gb_full, partner_gb_half} <= v[4:0];
		ms_fault_event <= 1'b1;
		@(posedge aclk);
		ms_fault_event <= 1'b0;
		rc(A_STAT, {16'h0, 1'b1, v[4:0], 10'h0}, RESP_OKAY);
		rc(A_STAT, {16'h0, 1'b0, v[4:0], 10'h0}, RESP_OKAY);
		for (k = 0; k < 2; k++) begin
			n = (k == 0) ? $urandom_range(254, 1) : 300;
			idle_error_event <= 1'b1;
			repeat (n) @(posedge aclk);
			idle_error_event <= 1'b0;
			rc(A_STAT, {16'h0, 1'b0, v[4:0], 2'b0, (n > 255) ? 8'hFF : n[7:0]}, RESP_OKAY);
			rc(A_STAT, {16'h0, 1'b0, v[4:0], 10'h0}, RESP_OKAY);
		end
		for (k = 0; k < 2; k++) begin
			v = (k == 0) ? 32'hFFFF_FFFF : $urandom;
			fx_events <= v[5:0];
			gb_events <= v[12:6];
			{fx_descr_locked, fx_link_up, gb_descr_locked, gb_link_up} <= v[18:15];
			{gb_noncompliant_partner, gb_crossover_error} <= v[14:13];
			@(posedge aclk);
			fx_events <= 6'h00;
			gb_events <= 7'h00;
			rc(A_FX, fx_exp(v, 1'b1), RESP_OKAY);
			rc(A_FX, fx_exp(v, 1'b0), RESP_OKAY);
			rc(A_GB, gb_exp(v, 1'b1), RESP_OKAY);
			rc(A_GB, gb_exp(v, 1'b0), RESP_OKAY);
		end
		for (n = 1; n < 4; n++) begin
			v = $urandom;
			a = v[15:0];
			wc(A_XCTL, {16'h0, 2'h0, 9'h0, v[4:0]}, RESP_OKAY);
			wc(A_WIN, {16'h0, a}, RESP_OKAY);
			rc(A_WIN, {16'h0, a}, RESP_OKAY);
			wc(A_XCTL, {16'h0, n[1:0], 9'h0, v[4:0]}, RESP_OKAY);
			rc(A_XCTL, {16'h0, n[1:0], 9'h0, v[4:0]}, RESP_OKAY);
			ck(32'(xa_device), 32'(v[4:0]));
			wc(A_WIN, {16'h0, v[31:16]}, RESP_OKAY);
			ck(32'(xa_wdata), 32'(v[31:16]));
			sh[a[3:0]] = v[31:16];
			a = a + {15'h0, n > 1};
			ck(32'(xa_address), 32'(a));
			rc(A_WIN, {16'h0, sh[a[3:0]]}, RESP_OKAY);
			a = a + {15'h0, n == 2};
			ck(32'(xa_address), 32'(a));
		end
		ck(32'(n_xw), 32'h3);
		ck(32'(n_xr), 32'h3);
		close_out();
	end
endmodule // gige_phy_control_status_regs_tb_top
`default_nettype wire

// >>> dv/gpcsr_asserts.sv
// Purpose: port checker for the gigabit register bank
// Assumes: single clock, synchronous active-low reset
// Notes: bound to every instance of the bank
`timescale 1ns/1ps
`default_nettype none
module gpcsr_chk (
	// clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// bus handshakes and read data
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// control outputs and the automatic role input
	input wire logic [2:0] test_mode,
	input wire logic       manual_role_en,
	input wire logic       manual_role_master,
	input wire logic       multi_port,
	input wire logic       adv_gb_full,
	input wire logic       adv_gb_half,
	input wire logic       role_is_master,
	input wire logic       auto_role_master,
	input wire logic       xa_write
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_role;
		$past(aresetn) |-> role_is_master ==
			($past(manual_role_en) ? $past(manual_role_master) : $past(auto_role_master));
	endproperty
	property p_rst;
		$rose(aresetn) |-> test_mode == 3'h0 && !manual_role_en && !multi_port && adv_gb_full && adv_gb_half;
	endproperty
	property p_bresp;
		s_wr_taken |-> ##[1:2] s_axi_bvalid;
	endproperty
	property p_rresp;
		s_rd_taken |=> s_axi_rvalid;
	endproperty
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
	endproperty
	property p_arblk;
		s_axi_rvalid && !s_axi_rready |=> !s_axi_arready && $stable(s_axi_rdata);
	endproperty
	property p_xa;
		xa_write |=> !xa_write;
	endproperty
	a_role: assert property (p_role) else $error("role output wrong");
	a_rst: assert property (p_rst) else $error("control reset value wrong");
	a_bresp: assert property (p_bresp) else $error("write answer late");
	a_rresp: assert property (p_rresp) else $error("read answer late");
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	a_arblk: assert property (p_arblk) else $error("read answer changed or overrun while waiting");
	a_xa: assert property (p_xa) else $error("access write pulse too long");
endmodule // gpcsr_chk
bind gpcsr_regs gpcsr_chk u_chk (.*);
`default_nettype wire

// >>> dv/gpcsr_xdev.sv
// Purpose: extended device model behind the access port
// Assumes: sixteen words, low address bits select one
// Notes: writes land on the address held before the pulse
`timescale 1ns/1ps
`default_nettype none
module gpcsr_xdev (
	// clock
	input  wire logic        aclk,
	// access port
	input  wire logic [15:0] xa_address,
	input  wire logic [15:0] xa_wdata,
	input  wire logic        xa_write,
	output logic [15:0]      xa_rdata
);
	logic [15:0] mem [16] = '{default: 16'h0000};
	logic [15:0] prev = 16'h0000;
	// address seen before any post-increment
	always_ff @(posedge aclk) begin
		prev <= xa_address;
		if (xa_write) mem[prev[3:0]] <= xa_wdata;
	end
	// read data follows the address at once
	assign xa_rdata = mem[xa_address[3:0]];
endmodule // gpcsr_xdev
`default_nettype wire

// >>> include/gpcsr_pkg.sv
// Purpose: constants for the gigabit phy control/status register bank
// Assumes: register indices as printed; byte address is four times the index
// Notes: bit positions, reset values and bus answer codes live here

package gpcsr_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned REG_W  = 16;
	// register indices
	localparam logic [5:0] IDX_GB_CTRL  = 6'h09;
	localparam logic [5:0] IDX_GB_STAT  = 6'h0A;
	localparam logic [5:0] IDX_XA_CTRL  = 6'h0D;
	localparam logic [5:0] IDX_XA_WIN   = 6'h0E;
	localparam logic [5:0] IDX_XABILITY = 6'h0F;
	localparam logic [5:0] IDX_FX_STAT  = 6'h10;
	localparam logic [5:0] IDX_GB_XSTAT = 6'h11;
	// gigabit control fields
	localparam int unsigned CTRL_TM_LSB  = 13;
	localparam int unsigned CTRL_MAN_EN  = 12;
	localparam int unsigned CTRL_MAN_VAL = 11;
	localparam int unsigned CTRL_PORT    = 10;
	localparam int unsigned CTRL_ADV_FD  = 9;
	localparam int unsigned CTRL_ADV_HD  = 8;
	localparam logic [2:0] TM_RESET      = 3'h0;
	localparam logic       ADV_RESET     = 1'b1;
	// extended access control fields
	localparam int unsigned XA_FN_LSB    = 14;
	localparam logic [1:0] FN_ADDR       = 2'h0;
	localparam logic [1:0] FN_DATA       = 2'h1;
	localparam logic [1:0] FN_DATA_INC   = 2'h2;
	localparam logic [1:0] FN_DATA_INCW  = 2'h3;
	localparam logic [15:0] WIN_RESET    = 16'h0000;
	// fixed ability word: copper full/half one, fibre zero
	localparam logic [15:0] XABILITY_VAL = 16'h3000;
	localparam logic [7:0] IDLE_MAX      = 8'hFF;
	// axi answer codes
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_DECERR   = 2'h3;
endpackage
